// [rtl/rftar_map.svh]
/*
  Constants for the tag-side anticollision responder: register offsets,
  field positions, reset values, protocol codes and timing counts.
  Assumes a 10 MHz system clock; included by the package only.
*/
`ifndef RFTAR_MAP_SVH
`define RFTAR_MAP_SVH

// timing
`define RFTAR_CLK_PERIOD_NS   100
`define RFTAR_T1_NOM_NS       320900
`define RFTAR_T1_CYC          ((`RFTAR_T1_NOM_NS) / (`RFTAR_CLK_PERIOD_NS))

// register byte offsets
`define RFTAR_OFS_CTRL        8'h00
`define RFTAR_OFS_STATUS      8'h04
`define RFTAR_OFS_UID_LO      8'h08
`define RFTAR_OFS_UID_HI      8'h0C
`define RFTAR_OFS_CFG         8'h10
`define RFTAR_OFS_RXCMD       8'h14
`define RFTAR_OFS_ERR         8'h18

// reset values
`define RFTAR_RST_ENABLE      1'b1
`define RFTAR_RST_UID         64'h0000_0000_0000_0000
`define RFTAR_RST_FAMILY      8'h00
`define RFTAR_RST_DSFID       8'h00

// request and response flag positions (bit 1 of the printed numbering is index 0)
`define RFTAR_RQ_INVENTORY    2
`define RFTAR_RQ_FAMILY       4
`define RFTAR_RQ_ONE_SLOT     5
`define RFTAR_RSP_ERROR       0

// command codes
`define RFTAR_CMD_INVENTORY   8'h01
`define RFTAR_CMD_FAST_INIT_INV 8'hC1
`define RFTAR_CMD_FAST_INIT   8'hC2
`define RFTAR_CMD_INIT_INV    8'hD1
`define RFTAR_CMD_INIT        8'hD2

// error codes
`define RFTAR_ERR_OPTION      8'h03
`define RFTAR_ERR_GENERIC     8'h0F
`define RFTAR_ERR_NO_BLOCK    8'h10
`define RFTAR_ERR_RELOCK      8'h11
`define RFTAR_ERR_LOCKED      8'h12
`define RFTAR_ERR_PROG        8'h13
`define RFTAR_ERR_LOCK_FAIL   8'h14
`define RFTAR_ERR_READ_PROT   8'h15

// crc16, lsb first
`define RFTAR_CRC_INIT        16'hFFFF
`define RFTAR_CRC_POLY        16'h8408
`define RFTAR_CRC_RESIDUE     16'hF0B8

// frame buffer
`define RFTAR_MAX_BYTES       14
`define RFTAR_MAX_MASK_BITS   7'd64

`endif

// [rtl/rftar_pkg.sv]
/*
  Types for the tag-side anticollision responder.
  Assumes rftar_map.svh is on the include path.
*/
`include "rftar_map.svh"

package rftar_pkg;

  typedef enum logic [2:0] {
    RFTAR_IDLE = 3'b001,
    RFTAR_RX   = 3'b010,
    RFTAR_SLOT = 3'b100
  } rftar_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } rftar_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } rftar_wb_rsp_t;

  typedef struct packed {
    logic field;
    logic frm;
    logic dat;
    logic clk;
  } rftar_link_t;

  typedef struct packed {
    logic        valid;
    logic        fast;
    logic [7:0]  flags;
    logic [7:0]  code;
    logic [7:0]  dsfid;
    logic [63:0] unique_identifier;
  } rftar_resp_t;

endpackage : rftar_pkg

// [rtl/rftar_responder.sv]
/*
  Tag-side anticollision responder: receives request frames from the
  demodulator link, runs the slotted inventory, hands answers to the
  modulator and reports error responses on software's request.
  Assumes link pins asynchronous to clk_i; a Wishbone master on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module rftar_responder
  import rftar_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire rftar_pkg::rftar_wb_req_t wb_i,
  output var  rftar_pkg::rftar_wb_rsp_t wb_o,
  input  wire rftar_pkg::rftar_link_t   link_i,
  output var  rftar_pkg::rftar_resp_t   resp_o
);
  import rftar_pkg::*;

  localparam int          NB  = `RFTAR_MAX_BYTES;
  localparam logic [11:0] T1C = 12'(`RFTAR_T1_CYC);

  typedef struct packed {
    logic [3:0][2:0]      sync;
    logic [3:0]           filt;
    rftar_state_t         st;
    logic                 live;
    logic [6:0]           nbits;
    logic [7:0]           sh;
    logic [NB-1:0][7:0]   buff;
    logic [15:0]          crc;
    logic                 over;
    logic [6:0]           mlen;
    logic [63:0]          mask;
    logic                 one;
    logic [3:0]           sn;
    logic                 fast;
    logic                 initiated;
    logic [11:0]          t1;
    logic                 pend;
    logic                 perr;
    logic [7:0]           pcode;
    logic                 en;
    logic [63:0]          unique_identifier;
    logic [7:0]           family;
    logic [7:0]           dsfid;
    logic [7:0]           rx_cmd;
    logic [7:0]           rx_flags;
    logic                 rx_new;
    rftar_resp_t          resp;
    rftar_wb_rsp_t        wb;
  } rftar_regs_t;

  rftar_regs_t q;
  rftar_regs_t next_q;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic slot_hit(
    input logic [63:0] unique_identifier,
    input logic [63:0] mask,
    input logic [6:0]  mlen,
    input logic [3:0]  sn,
    input logic        one
  );
    logic [71:0] lo_m;
    logic [71:0] all_m;
    logic [71:0] tgt;
    logic [6:0]  w;
    w     = one ? 7'h0 : 7'h4;
    lo_m  = (72'h1 << mlen) - 72'h1;
    all_m = (72'h1 << (mlen + w)) - 72'h1;
    tgt   = ({68'h0, (one ? 4'h0 : sn)} << mlen) | ({8'h0, mask} & lo_m);
    return (({8'h0, unique_identifier} ^ tgt) & all_m) == 72'h0;
  endfunction : slot_hit

  function automatic logic [7:0] legal_code(input logic [7:0] c);
    logic ok;
    ok = (c == `RFTAR_ERR_OPTION) || (c == `RFTAR_ERR_GENERIC)
      || (c == `RFTAR_ERR_NO_BLOCK) || (c == `RFTAR_ERR_RELOCK)
      || (c == `RFTAR_ERR_LOCKED) || (c == `RFTAR_ERR_PROG)
      || (c == `RFTAR_ERR_LOCK_FAIL) || (c == `RFTAR_ERR_READ_PROT);
    return ok ? c : `RFTAR_ERR_GENERIC;
  endfunction : legal_code

  function automatic logic [31:0] wr_bytes(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0]  sel
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : wr_bytes

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [3:0]  newf;
    logic [3:0]  rise;
    logic [3:0]  fall;
    logic        bitv;
    logic [3:0]  nbytes;
    logic        good;
    logic [7:0]  flg;
    logic [7:0]  cmd;
    logic [3:0]  base;
    logic [7:0]  mlen8;
    logic [7:0]  mbytes;
    logic [7:0]  expect_n;
    logic [63:0] mval;
    logic        fam_ok;
    logic        inv_cmd;
    logic        acc;
    logic [31:0] rd;
    logic        rx_clr;
    logic        rx_set;
    logic [7:0]  idx;
    newf     = q.filt;
    rise     = 4'h0;
    fall     = 4'h0;
    bitv     = 1'b0;
    nbytes   = q.nbits[6:3];
    good     = 1'b0;
    flg      = q.buff[0];
    cmd      = q.buff[1];
    base     = 4'h2;
    mlen8    = 8'h00;
    mbytes   = 8'h00;
    expect_n = 8'h00;
    mval     = 64'h0000_0000_0000_0000;
    fam_ok   = 1'b0;
    inv_cmd  = 1'b0;
    acc      = 1'b0;
    rd       = 32'h0000_0000;
    rx_clr   = 1'b0;
    rx_set   = 1'b0;
    idx      = 8'h00;
    next_q   = q;
    next_q.resp.valid = 1'b0;
    next_q.wb.ack     = 1'b0;

    // link pins: a change counts once the second and third stages agree
    for (int i = 0; i < 4; i++) begin
      next_q.sync[i] = {q.sync[i][1:0], link_i[i]};
      if (q.sync[i][1] == q.sync[i][2]) begin
        newf[i] = q.sync[i][2];
      end
    end
    next_q.filt = newf;
    rise = newf & ~q.filt;
    fall = ~newf & q.filt;
    bitv = q.sync[1][2];

    if (q.t1 != 12'h000) begin
      next_q.t1 = q.t1 - 12'h001;
    end

    case (q.st)
      RFTAR_IDLE, RFTAR_SLOT: begin
        // the round survives the sof until the frame proves valid
        if (rise[2] && q.en) begin
          next_q.st    = RFTAR_RX;
          next_q.live  = (q.st == RFTAR_SLOT);
          next_q.nbits = 7'h00;
          next_q.crc   = `RFTAR_CRC_INIT;
          next_q.over  = 1'b0;
          next_q.pend  = 1'b0;
        end
      end
      RFTAR_RX: begin
        if (rise[0]) begin
          next_q.sh  = {bitv, q.sh[7:1]};
          next_q.crc = (q.crc >> 1) ^ (((q.crc[0] ^ bitv) != 1'b0) ? `RFTAR_CRC_POLY : 16'h0000);
          if (q.nbits == 7'h7F) begin
            next_q.over = 1'b1;
          end else begin
            next_q.nbits = q.nbits + 7'h01;
          end
          if (q.nbits[2:0] == 3'h7) begin
            if (nbytes < 4'(NB)) begin
              next_q.buff[nbytes] = {bitv, q.sh[7:1]};
            end else begin
              next_q.over = 1'b1;
            end
          end
        end
        // falling frame level is the rising edge of the eof, any depth
        if (fall[2]) begin
          next_q.t1 = T1C;
          good = (q.crc == `RFTAR_CRC_RESIDUE) && !q.over
              && (q.nbits[2:0] == 3'h0) && (nbytes >= 4'h4);
          if (q.nbits == 7'h00) begin
            // bare eof: slot marker
            next_q.st = RFTAR_IDLE;
            if (q.live && (q.sn < (q.one ? 4'h0 : 4'hF))) begin
              next_q.st   = RFTAR_SLOT;
              next_q.sn   = q.sn + 4'h1;
              next_q.pend = slot_hit(q.unique_identifier, q.mask, q.mlen,
                                     q.sn + 4'h1, q.one);
              next_q.perr = 1'b0;
            end
          end else if (!good) begin
            next_q.st = q.live ? RFTAR_SLOT : RFTAR_IDLE;
          end else begin
            next_q.st   = RFTAR_IDLE;
            next_q.live = 1'b0;
            base   = flg[`RFTAR_RQ_FAMILY] ? 4'h3 : 4'h2;
            mlen8  = q.buff[base];
            mbytes = 8'((9'(mlen8) + 9'h007) >> 3);
            expect_n = 8'(base) + 8'h01 + mbytes + 8'h02;
            for (int i = 0; i < 8; i++) begin
              idx = 8'(base) + 8'h01 + 8'(i);
              if (idx < 8'(NB)) begin
                mval[i*8 +: 8] = q.buff[idx[3:0]];
              end
            end
            fam_ok = !flg[`RFTAR_RQ_FAMILY] || (q.buff[2] == 8'h00)
                  || (q.buff[2] == q.family);
            inv_cmd = (cmd == `RFTAR_CMD_INVENTORY)
                   || (q.initiated && ((cmd == `RFTAR_CMD_INIT_INV)
                   || (cmd == `RFTAR_CMD_FAST_INIT_INV)));
            if (flg[`RFTAR_RQ_INVENTORY] && inv_cmd) begin
              // malformed inventory requests get no answer at all
              if ((mlen8 <= 8'(`RFTAR_MAX_MASK_BITS)) && fam_ok
                  && (8'(nbytes) == expect_n)) begin
                next_q.st   = RFTAR_SLOT;
                next_q.live = 1'b1;
                next_q.sn   = 4'h0;
                next_q.mlen = mlen8[6:0];
                next_q.mask = mval;
                next_q.one  = flg[`RFTAR_RQ_ONE_SLOT];
                next_q.fast = (cmd == `RFTAR_CMD_FAST_INIT_INV);
                next_q.perr = 1'b0;
                next_q.pend = slot_hit(q.unique_identifier, mval, mlen8[6:0], 4'h0,
                                       flg[`RFTAR_RQ_ONE_SLOT]);
              end
            end else if ((cmd == `RFTAR_CMD_INIT) || (cmd == `RFTAR_CMD_FAST_INIT)) begin
              next_q.initiated = 1'b1;
              next_q.fast = (cmd == `RFTAR_CMD_FAST_INIT);
              next_q.perr = 1'b0;
              next_q.pend = 1'b1;
            end else begin
              // everything else goes to software for handling
              rx_set = 1'b1;
              next_q.rx_cmd   = cmd;
              next_q.rx_flags = flg;
            end
          end
        end
      end
      default: begin
        next_q.st = RFTAR_IDLE;
      end
    endcase

    // answers only leave after the response delay from the last eof
    if (q.pend && (q.t1 == 12'h000) && (q.st != RFTAR_RX)) begin
      next_q.pend        = 1'b0;
      next_q.resp.valid  = 1'b1;
      next_q.resp.fast   = q.fast && !q.perr;
      next_q.resp.flags  = 8'h00;
      next_q.resp.flags[`RFTAR_RSP_ERROR] = q.perr;
      next_q.resp.code   = q.perr ? q.pcode : 8'h00;
      next_q.resp.dsfid  = q.dsfid;
      next_q.resp.unique_identifier    = q.unique_identifier;
    end

    ////////////////////////////////////////////////////////////////////
    // wishbone slave: answer one cycle after the request appears

    acc = wb_i.cyc && wb_i.stb && !q.wb.ack;
    if (acc) begin
      next_q.wb.ack = 1'b1;
      if (wb_i.adr == `RFTAR_OFS_CTRL) begin
        rd = {30'h0000_0000, q.rx_new, q.en};
        if (wb_i.we && wb_i.sel[0]) begin
          next_q.en = wb_i.dat[0];
          rx_clr    = wb_i.dat[1];
        end
      end else if (wb_i.adr == `RFTAR_OFS_STATUS) begin
        rd = {20'h0_0000, q.rx_new, q.filt[3], q.pend, q.initiated,
              q.sn, q.live, q.st};
      end else if (wb_i.adr == `RFTAR_OFS_UID_LO) begin
        rd = q.unique_identifier[31:0];
        if (wb_i.we) begin
          next_q.unique_identifier[31:0] = wr_bytes(q.unique_identifier[31:0], wb_i.dat, wb_i.sel);
        end
      end else if (wb_i.adr == `RFTAR_OFS_UID_HI) begin
        rd = q.unique_identifier[63:32];
        if (wb_i.we) begin
          next_q.unique_identifier[63:32] = wr_bytes(q.unique_identifier[63:32], wb_i.dat, wb_i.sel);
        end
      end else if (wb_i.adr == `RFTAR_OFS_CFG) begin
        rd = {16'h0000, q.dsfid, q.family};
        if (wb_i.we) begin
          {next_q.dsfid, next_q.family} =
            16'(wr_bytes({16'h0000, q.dsfid, q.family}, wb_i.dat, wb_i.sel));
        end
      end else if (wb_i.adr == `RFTAR_OFS_RXCMD) begin
        rd = {16'h0000, q.rx_flags, q.rx_cmd};
      end else if (wb_i.adr == `RFTAR_OFS_ERR) begin
        rd = {24'h00_0000, q.pcode};
        if (wb_i.we && wb_i.sel[0]) begin
          next_q.pcode = legal_code(wb_i.dat[7:0]);
          next_q.perr  = 1'b1;
          next_q.pend  = 1'b1;
        end
      end else begin
        rd = 32'h0000_0000;
      end
      next_q.wb.dat = rd;
    end

    // a new request wins over software's acknowledge in the same cycle
    if (rx_clr) begin
      next_q.rx_new = 1'b0;
    end
    if (rx_set) begin
      next_q.rx_new = 1'b1;
    end

    // field loss drops any round in progress
    if (!newf[3]) begin
      next_q.st        = RFTAR_IDLE;
      next_q.live      = 1'b0;
      next_q.sn        = 4'h0;
      next_q.pend      = 1'b0;
      next_q.initiated = 1'b0;
      next_q.t1        = 12'h000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q           <= '0;
      q.st        <= RFTAR_IDLE;
      q.crc       <= `RFTAR_CRC_INIT;
      q.en        <= `RFTAR_RST_ENABLE;
      q.unique_identifier       <= `RFTAR_RST_UID;
      q.family    <= `RFTAR_RST_FAMILY;
      q.dsfid     <= `RFTAR_RST_DSFID;
    end else begin
      q <= next_q;
    end
  end

  assign wb_o   = q.wb;
  assign resp_o = q.resp;

endmodule : rftar_responder

`default_nettype wire

// [test/rftar_chk.sv]
/*
  Port checker for the anticollision responder: bus handshake, answer
  timing, error codes. Assumes it is bound onto rftar_responder.
*/
`timescale 1ns/1ps
`default_nettype none

module rftar_chk
  import rftar_pkg::*;
(
  input wire logic                     clk_i,
  input wire logic                     rst_i,
  input wire rftar_pkg::rftar_wb_req_t wb_i,
  input wire rftar_pkg::rftar_wb_rsp_t wb_o,
  input wire rftar_pkg::rftar_link_t   link_i,
  input wire rftar_pkg::rftar_resp_t   resp_o
);
  logic [15:0] since_eof;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // saturating, so an answer long after any frame never looks on time
  always_ff @(posedge clk_i) begin
    if (rst_i) since_eof <= 16'hFFFF;
    else if ($fell(link_i.frm)) since_eof <= 16'h0001;
    else if (since_eof != 16'hFFFF) since_eof <= since_eof + 16'h0001;
  end

  //////////////////////////////
  ack_take_a: assert property (wb_i.cyc && wb_i.stb && !wb_o.ack |=> wb_o.ack)
    else $error("request not acknowledged next cycle");
  ack_pulse_a: assert property (wb_o.ack |=> !wb_o.ack)
    else $error("acknowledge longer than one cycle");
  ack_cause_a: assert property (wb_o.ack |-> $past(wb_i.stb) && $past(wb_i.cyc))
    else $error("acknowledge without request");
  rdat_hold_a: assert property (!wb_o.ack |-> $stable(wb_o.dat))
    else $error("read data moved without acknowledge");
  answer_pulse_a: assert property (resp_o.valid |=> !resp_o.valid)
    else $error("answer strobe longer than one cycle");
  answer_hold_a: assert property (!resp_o.valid |-> $stable(resp_o.unique_identifier) && $stable(resp_o.code))
    else $error("answer payload moved between answers");
  err_code_a: assert property (resp_o.valid && resp_o.flags[0] |->
    resp_o.code inside {8'h03, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15})
    else $error("error answer with undefined code");
  ok_code_a: assert property (resp_o.valid && !resp_o.flags[0] |-> resp_o.flags == 8'h00 && resp_o.code == 8'h00)
    else $error("plain answer carries error fields");
  // 318.6 to 323.3 us from the eof on the pin; filter latency sits inside
  answer_delay_a: assert property (resp_o.valid && !resp_o.flags[0] |->
    since_eof >= 16'h0C72 && since_eof <= 16'h0CA1)
    else $error("answer outside response delay window");
  sof_cancel_a: assert property (link_i.frm && $past(link_i.frm, 8) |-> !resp_o.valid)
    else $error("answer during incoming frame");
  no_field_a: assert property (!link_i.field && !$past(link_i.field, 8) |-> !resp_o.valid)
    else $error("answer without field");
endmodule : rftar_chk

bind rftar_responder rftar_chk i_rftar_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
  .link_i(link_i), .resp_o(resp_o));

`default_nettype wire

// [test/rftar_reader.sv]
/*
  Reader model: frames requests and slot markers onto the link.
  Assumes clk_i is the responder clock; one link bit lasts 8 clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module rftar_reader
  import rftar_pkg::*;
(
  input  wire logic                   clk_i,
  output var  rftar_pkg::rftar_link_t link_o
);
  initial link_o = '0;

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  task automatic power(input logic on);
    @(posedge clk_i);
    link_o.field <= on;
  endtask : power

  // link clock runs only inside frames
  task automatic put_bit(input logic b);
    link_o.dat <= b;
    tick(2);
    link_o.clk <= 1'b1;
    tick(4);
    link_o.clk <= 1'b0;
    tick(2);
  endtask : put_bit

  // every round opens with a request frame; lsb first, crc inverted
  task automatic send(input logic [7:0] q [$], input logic bad);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) for (int k = 0; k < 8; k++) c = (c >> 1) ^ ((c[0] ^ q[i][k]) ? 16'h8408 : 16'h0000);
    c = ~c ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    @(posedge clk_i);
    link_o.frm <= 1'b1;
    tick(4);
    foreach (q[i]) for (int k = 0; k < 8; k++) put_bit(q[i][k]);
    link_o.frm <= 1'b0;
    link_o.dat <= ~link_o.dat;
  endtask : send

  // bare slot marker; modulation depth does not reach this link
  task automatic eof;
    @(posedge clk_i);
    link_o.frm <= 1'b1;
    tick(8);
    link_o.frm <= 1'b0;
  endtask : eof
endmodule : rftar_reader

`default_nettype wire

// [test/rftar_responder_test.sv]
/*
  Testbench for the anticollision responder: register access, slotted
  rounds, initiate commands, error answers. Assumes reader model, checker.
*/
`timescale 1ns/1ps
`default_nettype none

module rftar_responder_test;
  import rftar_pkg::*;
  // low 15 bits 16B7h: 11-bit mask 6B7h sits under slot index 2, low nibble 7
  localparam logic [63:0] UNIQUE_IDENTIFIER    = 64'hA5C3_0F1E_2D3C_16B7;
  localparam int          T2_CYC = 3092;
  logic          clk_i;
  logic          rst_i;
  rftar_wb_req_t wb_i;
  rftar_wb_rsp_t wb_o;
  rftar_link_t   link;
  rftar_resp_t   resp_o;
  int            failures;
  int            n_compared;
  logic [31:0]   rd;
  logic [7:0]    codes [9] = '{8'h03, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h3C};

  rftar_responder i_rftar_responder (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
    .link_i(link), .resp_o(resp_o));
  rftar_reader i_rftar_reader (.clk_i(clk_i), .link_o(link));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  //////////////////////////////
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  task automatic cmp_resp(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp_resp

  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
    cmp_resp({32'h0000_0000, g}, {32'h0000_0000, e});
  endtask : cmp_reg

  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_i <= '{1'b1, 1'b1, we, a, 4'hF, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_o.ack !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    rd = wb_o.dat;
    wb_i <= '0;
  endtask : wb_xfer

  // e is {fast, flags, code}; turn adds the reader turnaround after an answer
  task automatic listen(input logic exp, input logic [16:0] e, input logic turn);
    logic got;
    got = 1'b0;
    // valid stands one cycle, so look before waiting for the next edge
    for (int i = 0; i < 3300 && !got; i++) begin
      #1 got = (resp_o.valid === 1'b1);
      if (!got) @(posedge clk_i);
    end
    cmp_reg({31'h0000_0000, got}, {31'h0000_0000, exp});
    if (got && exp) cmp_reg({15'h0000, resp_o.fast, resp_o.flags, resp_o.code}, {15'h0000, e});
    if (got && exp && !e[8]) cmp_resp(resp_o.unique_identifier, UNIQUE_IDENTIFIER);
    if (got && turn) repeat (T2_CYC) @(posedge clk_i);
  endtask : listen

  task automatic inv(input logic [7:0] fl, input logic [7:0] cmd, input int mlen, input logic [63:0] mask,
                     input logic bad);
    logic [7:0]  q [$];
    logic [63:0] m;
    m = mask & ((64'h1 << mlen) - 64'h1);
    q = '{fl, cmd};
    if (fl[4]) q.push_back(8'h5A);
    q.push_back(8'(mlen));
    for (int b = 0; b < (mlen + 7) / 8; b++) q.push_back(m[8*b +: 8]);
    i_rftar_reader.send(q, bad);
  endtask : inv

  //////////////////////////////
  initial begin
    rst_i = 1'b1;
    wb_i = '0;
    failures = 0;
    n_compared = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_xfer(1'b0, 8'h00, 32'h0000_0000);
    cmp_reg(rd, 32'h0000_0001);
    wb_xfer(1'b0, 8'h04, 32'h0000_0000);
    cmp_reg(rd, 32'h0000_0001);
    wb_xfer(1'b0, 8'h1C, 32'h0000_0000);
    cmp_reg(rd, 32'h0000_0000);
    wb_xfer(1'b1, 8'h08, UNIQUE_IDENTIFIER[31:0]);
    wb_xfer(1'b1, 8'h0C, UNIQUE_IDENTIFIER[63:32]);
    wb_xfer(1'b1, 8'h10, 32'h0000_3C5A);
    wb_xfer(1'b0, 8'h0C, 32'h0000_0000);
    cmp_reg(rd, UNIQUE_IDENTIFIER[63:32]);
    i_rftar_reader.power(1'b1);
    repeat (10) @(posedge clk_i);
    inv(8'h04, 8'h01, 0, 64'h0, 1'b0);
    listen(1'b0, 17'h0_0000, 1'b1);
    i_rftar_reader.eof();
    listen(1'b0, 17'h0_0000, 1'b1);
    inv(8'h14, 8'h01, 11, 64'h06B7, 1'b0);
    listen(1'b0, 17'h0_0000, 1'b1);
    i_rftar_reader.eof();
    listen(1'b0, 17'h0_0000, 1'b1);
    i_rftar_reader.eof();
    listen(1'b1, 17'h0_0000, 1'b1);
    cmp_reg({24'h00_0000, resp_o.dsfid}, 32'h0000_003C);
    inv(8'h24, 8'h01, 4, 64'h7, 1'b0);
    listen(1'b1, 17'h0_0000, 1'b1);
    inv(8'h24, 8'h01, 4, 64'h3, 1'b0);
    listen(1'b0, 17'h0_0000, 1'b1);
    inv(8'h24, 8'h01, 0, 64'h0, 1'b1);
    listen(1'b0, 17'h0_0000, 1'b1);
    inv(8'h04, 8'h01, 0, 64'h0, 1'b0);
    repeat (20) @(posedge clk_i);
    wb_xfer(1'b0, 8'h04, 32'h0000_0000);
    cmp_reg(rd & 32'h0000_00FF, 32'h0000_000C);
    i_rftar_reader.power(1'b0);
    repeat (10) @(posedge clk_i);
    wb_xfer(1'b0, 8'h04, 32'h0000_0000);
    cmp_reg(rd & 32'h0000_04FF, 32'h0000_0001);
    i_rftar_reader.power(1'b1);
    repeat (10) @(posedge clk_i);
    inv(8'h24, 8'hD1, 0, 64'h0, 1'b0);
    listen(1'b0, 17'h0_0000, 1'b1);
    i_rftar_reader.send('{8'h00, 8'hD2}, 1'b0);
    listen(1'b1, 17'h0_0000, 1'b1);
    inv(8'h24, 8'hD1, 0, 64'h0, 1'b0);
    listen(1'b1, 17'h0_0000, 1'b1);
    i_rftar_reader.send('{8'h00, 8'hC2}, 1'b0);
    listen(1'b1, 17'h1_0000, 1'b1);
    inv(8'h24, 8'hC1, 0, 64'h0, 1'b0);
    listen(1'b1, 17'h1_0000, 1'b1);
    foreach (codes[i]) begin
      wb_xfer(1'b1, 8'h18, {24'h00_0000, codes[i]});
      listen(1'b1, {1'b0, 8'h01, (i == 8) ? 8'h0F : codes[i]}, 1'b0);
    end
    summarize();
  end

  initial begin
    // the tests need about 66k clocks; this limit keeps a hang under budget
    repeat (90000) @(posedge clk_i);
    failures++;
    summarize();
  end
endmodule : rftar_responder_test

`default_nettype wire
